//--- mtw_consts.vh
//------------------------------------------------------------
// table walk constants
//------------------------------------------------------------
// Overview of operation
// - section: bits 31:20 give 1MB base, done
// - section access permission from bits 11:10
// - domain from level one bits 8:5
// - memory type from bits 3:2
// - level one type 10 means section
// - coarse base bits 31:10, 256 entries
// - coarse descriptor starts level two fetch
// - level one type 01 means coarse
// - fine base bits 31:12, 1024 entries
// - fine descriptor starts level two fetch
// - level one type 11 means fine
// - permissions given with the physical address in the same strobe
// - page base 31:16, 31:12 or 31:10
// - subpage permissions 11:4, tiny 5:4
// - level two types: fault, large, small, tiny
// - coarse tables accept large or small only
// - level one address: root 31:14, va 31:20
// - level one type 00 is section fault
`ifndef MTW_CONSTS_VH
`define MTW_CONSTS_VH
// register offsets (byte addresses)
`define MTW_REG_ROOT 8'h00
`define MTW_REG_STATUS 8'h04
`define MTW_REG_LAST_PA 8'h08
`define MTW_REG_LAST_INFO 8'h0C
// root pointer layout and reset
`define MTW_ROOT_LSB 14
`define MTW_ROOT_RESET 32'h0000_0000
// status bit positions
`define MTW_ST_BUSY 0
`define MTW_ST_FAULT 1
`define MTW_ST_FAULT_PAGE 2
// descriptor type codes, level one
`define MTW_L1_FAULT 2'h0
`define MTW_L1_COARSE 2'h1
`define MTW_L1_SECTION 2'h2
`define MTW_L1_FINE 2'h3
// descriptor type codes, level two
`define MTW_L2_FAULT 2'h0
`define MTW_L2_LARGE 2'h1
`define MTW_L2_SMALL 2'h2
`define MTW_L2_TINY 2'h3
// result kind codes
`define MTW_KIND_SECTION 2'h0
`define MTW_KIND_LARGE 2'h1
`define MTW_KIND_SMALL 2'h2
`define MTW_KIND_TINY 2'h3
`endif

//--- mtw_walker.v
// The implementer's own choices: the register addresses and the address-and-strobe port.
`include "mtw_consts.vh"
`default_nettype none

module mtw_walker (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // walk request from the miss path
  input wire walk_req,
  input wire [31:0] virtual_request_address,
  output wire walk_ready,
  // walk result
  output reg walk_done,
  output reg walk_fault,
  output reg walk_fault_page,
  output reg [1:0] walk_kind,
  output reg [31:0] walk_phys_addr,
  output reg [3:0] walk_domain,
  output reg [1:0] access_permission_field,
  output reg [7:0] walk_subpage_perm,
  output reg [1:0] walk_mem_type,
  // descriptor fetch port
  output reg mem_req,
  output reg [31:0] mem_addr,
  input wire mem_ack,
  input wire [31:0] mem_rdata
);

  //------------------------------------------------------------
  // state machine encoding
  //------------------------------------------------------------
  // waiting for a miss from the core
  localparam S_IDLE = 2'h0;
  // level one fetch outstanding
  localparam S_L1 = 2'h1;
  // level two fetch outstanding
  localparam S_L2 = 2'h2;
  // code 2'h3 is unused and falls back to idle

  //------------------------------------------------------------
  // walk bookkeeping
  //------------------------------------------------------------
  reg [1:0] state_r; // walk phase
  reg [31:0] root_r; // walk_root_pointer, low bits kept zero
  reg [31:0] va_r; // captured virtual address
  reg [3:0] dom_r; // domain held from level one
  reg fine_r; // level two table is fine
  reg fault_r; // sticky fault flag for software
  reg fault_page_r; // last fault came from level two
  reg [31:0] last_pa_r; // last physical address produced
  reg [1:0] last_kind_r; // last translation kind

  //------------------------------------------------------------
  // descriptor decode
  //------------------------------------------------------------
  wire [1:0] l1_type; // level one descriptor type
  wire [1:0] l2_type; // level two descriptor type
  wire fault_set; // a walk ends in a fault this cycle
  wire fault_clr; // software clears the sticky fault

  // subpage permission fields of a large or small page
  wire [7:0] subpage_fields; // all four fields, subpage 0 lowest
  genvar sp_i; // subpage index for the field split
  wire [1:0] subpage_permission_0;
  wire [1:0] subpage_permission_1;
  wire [1:0] subpage_permission_2;
  wire [1:0] subpage_permission_3;

  assign l1_type = mem_rdata[1:0];
  assign l2_type = mem_rdata[1:0];
  // one two-bit slice per subpage, starting at descriptor bit 4
  generate
    for (sp_i = 0; sp_i < 4; sp_i = sp_i + 1) begin : g_subpage
      assign subpage_fields[2 * sp_i +: 2] = mem_rdata[2 * sp_i + 4 +: 2];
    end
  endgenerate
  assign subpage_permission_0 = subpage_fields[1:0];
  assign subpage_permission_1 = subpage_fields[3:2];
  assign subpage_permission_2 = subpage_fields[5:4];
  assign subpage_permission_3 = subpage_fields[7:6];

  // a new walk is only taken while idle
  // a busy walker ignores requests, and walk_ready shows it by staying low
  assign walk_ready = (state_r == S_IDLE);

  //------------------------------------------------------------
  // walk sequencer
  //------------------------------------------------------------
  // fetches one or two descriptors and publishes the result
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      // clear the sequencer and every result field
      state_r <= S_IDLE;
      va_r <= 32'h0000_0000;
      dom_r <= 4'h0;
      fine_r <= 1'b0;
      mem_req <= 1'b0;
      mem_addr <= 32'h0000_0000;
      walk_done <= 1'b0;
      walk_fault <= 1'b0;
      walk_fault_page <= 1'b0;
      walk_kind <= 2'h0;
      walk_phys_addr <= 32'h0000_0000;
      walk_domain <= 4'h0;
      access_permission_field <= 2'h0;
      walk_subpage_perm <= 8'h00;
      walk_mem_type <= 2'h0;
    end else begin
      // result strobe lasts one cycle
      // every other result field holds until the next strobe
      walk_done <= 1'b0;
      case (state_r)
        S_IDLE: begin
          // take a request and issue the level one fetch
          // the root pointer's low bits are zero, so only 31:14 matter
          if (walk_req) begin
            va_r <= virtual_request_address;
            mem_addr <= {root_r[31:`MTW_ROOT_LSB],
                         virtual_request_address[31:20], 2'h0};
            mem_req <= 1'b1;
            state_r <= S_L1;
          end
        end
        S_L1: begin
          // level one descriptor arrives with the acknowledge
          if (mem_ack) begin
            // domain is kept for a later level two result
            dom_r <= mem_rdata[8:5];
            case (l1_type)
              `MTW_L1_SECTION: begin
                // one fetch is enough for a section
                mem_req <= 1'b0;
                walk_done <= 1'b1;
                walk_fault <= 1'b0;
                walk_fault_page <= 1'b0;
                walk_kind <= `MTW_KIND_SECTION;
                // section keeps va bits 19:0 below its 1MB base
                walk_phys_addr <= {mem_rdata[31:20], va_r[19:0]};
                walk_domain <= mem_rdata[8:5];
                // permissions travel with the address in the same strobe
                access_permission_field <= mem_rdata[11:10];
                walk_subpage_perm <= {4{mem_rdata[11:10]}};
                walk_mem_type <= mem_rdata[3:2];
                state_r <= S_IDLE;
              end
              `MTW_L1_COARSE: begin
                // second fetch from a 256-entry coarse table
                // mem_req stays high into the level two fetch
                fine_r <= 1'b0;
                mem_addr <= {mem_rdata[31:10], va_r[19:12], 2'h0};
                state_r <= S_L2;
              end
              `MTW_L1_FINE: begin
                // second fetch from a 1024-entry fine table
                // mem_req stays high into the level two fetch
                fine_r <= 1'b1;
                mem_addr <= {mem_rdata[31:12], va_r[19:10], 2'h0};
                state_r <= S_L2;
              end
              default: begin
                // invalid entry gives a section translation fault
                // no second fetch: the walk ends here
                mem_req <= 1'b0;
                walk_done <= 1'b1;
                walk_fault <= 1'b1;
                walk_fault_page <= 1'b0;
                walk_kind <= `MTW_KIND_SECTION;
                walk_phys_addr <= 32'h0000_0000;
                walk_domain <= 4'h0;
                access_permission_field <= 2'h0;
                walk_subpage_perm <= 8'h00;
                walk_mem_type <= 2'h0;
                state_r <= S_IDLE;
              end
            endcase
          end
        end
        S_L2: begin
          // level two descriptor arrives with the acknowledge
          // domain comes from level one, the rest from level two
          if (mem_ack) begin
            mem_req <= 1'b0;
            walk_done <= 1'b1;
            walk_domain <= dom_r;
            walk_mem_type <= mem_rdata[3:2];
            walk_fault_page <= 1'b1;
            state_r <= S_IDLE;
            case (l2_type)
              `MTW_L2_LARGE: begin
                walk_fault <= 1'b0;
                walk_kind <= `MTW_KIND_LARGE;
                // 64KB page keeps va bits 15:0
                walk_phys_addr <= {mem_rdata[31:16], va_r[15:0]};
                walk_subpage_perm <= {subpage_permission_3, subpage_permission_2,
                                      subpage_permission_1, subpage_permission_0};
                // the subpage being accessed is va bits 15:14
                case (va_r[15:14])
                  2'h0: access_permission_field <= subpage_permission_0;
                  2'h1: access_permission_field <= subpage_permission_1;
                  2'h2: access_permission_field <= subpage_permission_2;
                  default: access_permission_field <= subpage_permission_3;
                endcase
              end
              `MTW_L2_SMALL: begin
                walk_fault <= 1'b0;
                walk_kind <= `MTW_KIND_SMALL;
                // 4KB page keeps va bits 11:0
                walk_phys_addr <= {mem_rdata[31:12], va_r[11:0]};
                walk_subpage_perm <= {subpage_permission_3, subpage_permission_2,
                                      subpage_permission_1, subpage_permission_0};
                // the subpage being accessed is va bits 11:10
                case (va_r[11:10])
                  2'h0: access_permission_field <= subpage_permission_0;
                  2'h1: access_permission_field <= subpage_permission_1;
                  2'h2: access_permission_field <= subpage_permission_2;
                  default: access_permission_field <= subpage_permission_3;
                endcase
              end
              `MTW_L2_TINY: begin
                // tiny pages only exist in fine tables
                if (fine_r) begin
                  walk_fault <= 1'b0;
                  walk_kind <= `MTW_KIND_TINY;
                  // 1KB page keeps va bits 9:0
                  // one permission field covers the whole page
                  walk_phys_addr <= {mem_rdata[31:10], va_r[9:0]};
                  access_permission_field <= mem_rdata[5:4];
                  walk_subpage_perm <= {4{mem_rdata[5:4]}};
                end else begin
                  // coarse table cannot hold a tiny page
                  walk_fault <= 1'b1;
                  walk_kind <= `MTW_KIND_TINY;
                  walk_phys_addr <= 32'h0000_0000;
                  access_permission_field <= 2'h0;
                  walk_subpage_perm <= 8'h00;
                end
              end
              default: begin
                // invalid entry gives a page translation fault
                // kind names the table size that faulted
                walk_fault <= 1'b1;
                walk_kind <= fine_r ? `MTW_KIND_TINY : `MTW_KIND_SMALL;
                walk_phys_addr <= 32'h0000_0000;
                access_permission_field <= 2'h0;
                walk_subpage_perm <= 8'h00;
              end
            endcase
          end
        end
        default: begin
          // unused code returns to idle
          mem_req <= 1'b0;
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  //------------------------------------------------------------
  // fault and history tracking
  //------------------------------------------------------------
  // a fault result also records which level raised it
  assign fault_set = walk_done & walk_fault;
  // software writes one to the fault bit to clear it
  assign fault_clr = reg_wr & (reg_addr == `MTW_REG_STATUS) & reg_wdata[`MTW_ST_FAULT];

  // sticky fault: a new fault wins over a clear in the same cycle
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      fault_r <= 1'b0;
      fault_page_r <= 1'b0;
    end else if (fault_set) begin
      fault_r <= 1'b1;
      fault_page_r <= walk_fault_page;
    end else if (fault_clr) begin
      // a software clear drops both bits together
      fault_r <= 1'b0;
      fault_page_r <= 1'b0;
    end
  end

  // keep the last good translation for software to inspect
  // faults leave the last good values untouched
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      last_pa_r <= 32'h0000_0000;
      last_kind_r <= 2'h0;
    end else if (walk_done & ~walk_fault) begin
      last_pa_r <= walk_phys_addr;
      last_kind_r <= walk_kind;
    end
  end

  //------------------------------------------------------------
  // register port
  //------------------------------------------------------------
  // root pointer write; low 14 bits always read as zero
  // writes to the low 14 bits are dropped
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      root_r <= `MTW_ROOT_RESET;
    end else if (reg_wr & (reg_addr == `MTW_REG_ROOT)) begin
      root_r <= {reg_wdata[31:`MTW_ROOT_LSB], 14'h0};
    end
  end

  //------------------------------------------------------------
  // register read-back
  //------------------------------------------------------------
  // read data stands in the cycle after the read strobe
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        // root pointer with its low bits zero
        `MTW_REG_ROOT: reg_rdata <= root_r;
        // state, fault level, sticky fault and busy
        `MTW_REG_STATUS: reg_rdata <= {27'h0, state_r, fault_page_r, fault_r, ~walk_ready};
        // last good physical address
        `MTW_REG_LAST_PA: reg_rdata <= last_pa_r;
        // domain of the current result and the last good kind
        `MTW_REG_LAST_INFO: reg_rdata <= {26'h0, walk_domain, last_kind_r};
        // unmapped addresses read as zero
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      // no read: the port rests at zero
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

//--- mtw_mem_model.sv
`default_nettype none
// ----------------------------------------
// descriptor memory behind the fetch port
// ----------------------------------------
module mtw_mem_model (
  // clock
  input wire logic clk_sys,
  // fetch port
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [31:0]];  // table words by byte address
  int wait_r = 0;  // cycles still to stall
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
  end
  // answer each fetch after a random stall, word garbled outside acks
  always @(posedge clk_sys) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (wait_r == 0) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_rdata;
        wait_r <= $urandom_range(0, 3);
      end else begin
        wait_r <= wait_r - 1;
      end
    end
  end
endmodule
`default_nettype wire

//--- mtw_monitor.sv
`default_nettype none
// ----------------------------------------
// walk protocol checker
// ----------------------------------------
module mtw_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // walk request and result
  input wire logic walk_req,
  input wire logic [31:0] virtual_request_address,
  input wire logic walk_ready,
  input wire logic walk_done,
  input wire logic walk_fault,
  input wire logic walk_fault_page,
  input wire logic [1:0] walk_kind,
  input wire logic [31:0] walk_phys_addr,
  input wire logic [3:0] walk_domain,
  input wire logic [1:0] access_permission_field,
  input wire logic [1:0] walk_mem_type,
  // fetch port
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic first_r;  // level one fetch still open
  logic [31:0] va_r;  // address of the accepted walk
  logic [31:0] d_r;  // last fetched word
  wire ack = mem_req && mem_ack;  // a fetch completes
  wire l1 = first_r && ack;  // level one word arrives
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // track walk start and fetched words
  always @(posedge clk_sys) begin
    if (!rst_n) first_r <= 1'b0;
    else if (walk_req && walk_ready) first_r <= 1'b1;
    else if (ack) first_r <= 1'b0;
    if (walk_req && walk_ready) va_r <= virtual_request_address;
    if (ack) d_r <= mem_rdata;
  end
  a_fetch_holds: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("fetch dropped or moved before ack");
  a_l1_addr: assert property (walk_req && walk_ready |=>
    mem_req && mem_addr[13:0] == {va_r[31:20], 2'b00}) else $error("bad level one address");
  a_section_done: assert property (l1 && mem_rdata[1:0] == 2'h2 |=> walk_done && !walk_fault
    && walk_kind == 2'h0 && walk_phys_addr == {d_r[31:20], va_r[19:0]})
    else $error("bad section result");
  a_section_fields: assert property (l1 && mem_rdata[1:0] == 2'h2 |=>
    access_permission_field == d_r[11:10] && walk_domain == d_r[8:5]
    && walk_mem_type == d_r[3:2]) else $error("bad section fields");
  a_coarse_fetch: assert property (l1 && mem_rdata[1:0] == 2'h1 |=> !walk_done
    && mem_req && mem_addr == {d_r[31:10], va_r[19:12], 2'b00}) else $error("bad coarse fetch");
  a_fine_fetch: assert property (l1 && mem_rdata[1:0] == 2'h3 |=> !walk_done
    && mem_req && mem_addr == {d_r[31:12], va_r[19:10], 2'b00}) else $error("bad fine fetch");
  a_l1_fault: assert property (l1 && mem_rdata[1:0] == 2'h0 |=> walk_done
    && walk_fault && !walk_fault_page && walk_domain == 4'h0) else $error("no section fault");
  a_page_fault: assert property (ack && !first_r && mem_rdata[1:0] == 2'h0 |=>
    walk_done && walk_fault && walk_fault_page) else $error("no page fault");
  a_done_pulse: assert property (walk_done |-> walk_ready && !mem_req ##1 !walk_done)
    else $error("done not a single idle pulse");
  c_section: cover property (l1 && mem_rdata[1:0] == 2'h2);
  c_tiny: cover property (ack && !first_r && mem_rdata[1:0] == 2'h3);
  c_fault: cover property (walk_done && walk_fault);
endmodule
bind mtw_walker mtw_monitor mon (.clk_sys, .rst_n, .walk_req, .virtual_request_address,
  .walk_ready, .walk_done, .walk_fault, .walk_fault_page, .walk_kind, .walk_phys_addr,
  .walk_domain, .access_permission_field, .walk_mem_type, .mem_req, .mem_addr, .mem_ack,
  .mem_rdata);
`default_nettype wire

//--- tb_top.sv
`default_nettype none
// ----------------------------------------
// walker bench
// ----------------------------------------
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
  logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, walk_req = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, va = 32'h0, root, v, d1, d2;
  wire [31:0] reg_rdata, walk_phys_addr, mem_addr, mem_rdata;
  wire walk_ready, walk_done, walk_fault, walk_fault_page, mem_req, mem_ack;
  wire [1:0] walk_kind, access_permission_field, walk_mem_type;
  wire [3:0] walk_domain;
  wire [7:0] walk_subpage_perm;
  int bad_count = 0, samples_checked = 0;
  logic af = 1'b0, fp = 1'b0;  // any fault seen, last fault from level two
  logic [31:0] lpa = 32'h0;  // last good physical address
  logic [3:0] ld = 4'h0;  // domain of the last result
  logic [1:0] lk = 2'h0;  // kind of the last good result
  logic [51:0] exp_q[$], msk_q[$], e, m, w, ew;  // notes of expected results
  mtw_walker dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .walk_req, .virtual_request_address(va), .walk_ready, .walk_done, .walk_fault,
    .walk_fault_page, .walk_kind, .walk_phys_addr, .walk_domain, .access_permission_field,
    .walk_subpage_perm, .walk_mem_type, .mem_req, .mem_addr, .mem_ack, .mem_rdata);
  mtw_mem_model mdl (.clk_sys, .mem_req, .mem_addr, .mem_ack, .mem_rdata);
  always #5 clk_sys = ~clk_sys;
  // register port cycles
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [31:0] x);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    `CHK(reg_rdata, x)
  endtask
  // expected result fields and the mask of fields that are defined
  function automatic void predict(input logic [31:0] v, d1, d2, output logic [51:0] e, m);
    logic f;
    logic [1:0] k, ap;
    logic [3:0] dom;
    logic [7:0] sp;
    logic [31:0] pa;
    int sh;
    f = d1[1:0] == 2'h0;
    k = 2'h0;
    dom = f ? 4'h0 : d1[8:5];
    pa = f ? 32'h0 : {d1[31:20], v[19:0]};
    ap = d1[11:10];
    sp = {4{d1[11:10]}};
    if (d1[0]) begin
      k = d2[1:0];
      sh = k == 2'h1 ? 16 : k == 2'h2 ? 12 : 10;
      pa = ((d2 >> sh) << sh) | (v & ((32'h1 << sh) - 32'h1));
      ap = d2[4 + 2 * (k == 2'h1 ? v[15:14] : v[11:10]) +: 2];
      sp = k == 2'h3 ? {4{d2[5:4]}} : d2[11:4];
      if (k == 2'h3) ap = d2[5:4];
      if (k == 2'h0 || (k == 2'h3 && !d1[1])) begin
        f = 1'b1;
        pa = 32'h0;
        if (k == 2'h0)
          k = d1[1] ? 2'h3 : 2'h2;
      end
    end
    e = {f, d1[0], k, pa, dom, ap, sp, d1[0] ? d2[3:2] : d1[3:2]};
    m = {2'b11, {2{d1[0] | ~f}}, {36{1'b1}}, {12{~f}}};
  endfunction
  // one walk: request, then bounded wait for the result pulse
  task automatic walk(input logic [31:0] a);
    walk_req <= 1'b1;
    va <= a;
    @(posedge clk_sys);
    walk_req <= 1'b0;
    for (int n = 0; n < 40 && walk_done !== 1'b1; n++) @(posedge clk_sys);
    if (walk_done !== 1'b1) begin
      bad_count++;
      results();
    end
  endtask
  // watcher: each result against the oldest note
  always @(posedge clk_sys) begin
    if (walk_done === 1'b1 && exp_q.size() > 0) begin
      w = {walk_fault, walk_fault_page, walk_kind, walk_phys_addr, walk_domain,
        access_permission_field, walk_subpage_perm, walk_mem_type} & msk_q.pop_front();
      ew = exp_q.pop_front();
      `CHK(w, ew)
    end
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // main sequence: root pointer, then every pair of descriptor types
  initial begin
    void'($urandom(32'h16BF));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    root = $urandom();
    reg_write(8'h00, root);
    reg_read(8'h00, root & 32'hFFFF_C000);
    reg_read(8'h10, 32'h0);
    for (int i = 0; i < 64; i++) begin
      v = $urandom();
      d1 = $urandom() | 32'h10;
      d1[1:0] = i[1:0];
      d1 &= d1[1:0] == 2'h2 ? 32'hFFF0_0DFF : d1[0] ? (d1[1] ? 32'hFFFF_F1F3 : 32'hFFFF_FDF3)
        : 32'hFFFF_FFFF;
      d2 = $urandom();
      d2[1:0] = i[3:2];
      mdl.mem.delete();
      mdl.mem[{root[31:14], v[31:20], 2'b00}] = d1;
      if (d1[0])
        mdl.mem[d1[1] ? {d1[31:12], v[19:10], 2'b00} : {d1[31:10], v[19:12], 2'b00}] = d2;
      predict(v, d1, d2, e, m);
      ld = e[15:12];
      if (e[51]) begin
        af = 1'b1;
        fp = e[50];
      end else begin
        lpa = e[47:16];
        lk = e[49:48];
      end
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      walk(v);
    end
    repeat (3) @(posedge clk_sys);
    `CHK(exp_q.size(), 0)
    reg_read(8'h04, {29'h0, fp, af, 1'b0});
    reg_write(8'h04, 32'h2);
    reg_read(8'h04, 32'h0);
    reg_read(8'h08, lpa);
    reg_read(8'h0C, {26'h0, ld, lk});
    results();
  end
endmodule
`default_nettype wire
